// ### src/adc_port_pkg.sv
/*
  Shared constants and types for the conversion result output port.
  Assumes a 100 MHz system clock and a 16-bit result word.
*/
package adc_port_pkg;
  localparam int WORD_W = 16;
  localparam int CFG_W = 8;
  localparam int CLK_PERIOD_NS = 10;

  // Positions of the pin inputs inside the synchroniser vector
  localparam int CFG_CS_N = 0;
  localparam int CFG_RD_N = 1;
  localparam int CFG_SERIAL = 2;
  localparam int CFG_FORMAT = 3;
  localparam int CFG_EXT_CLK = 4;
  localparam int CFG_FRAME_POL = 5;
  localparam int CFG_CLK_INV = 6;
  localparam int CFG_READ_MODE = 7;

  // Pins that double as serial port signals
  localparam int PIN_SDO = 8;
  localparam int PIN_SCLK = 9;
  localparam int PIN_FRAME = 10;
  localparam int PIN_RDERR = 11;

  // Internal serial clock: one bit lasts four system clocks
  localparam logic [1:0] PH_UPDATE = 2'h0;
  localparam logic [1:0] PH_HIGH = 2'h1;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  localparam int MASTER_FRAME_CYCLES = 64;
  localparam logic [4:0] CHAIN_DELAY = 5'h10;
  localparam logic [4:0] EDGE_SAT = 5'h1f;

  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_CFG = 8'h03;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_HOLD = 3'b100
  } master_state_t;
endpackage

// ### src/serial_link_if.sv
/*
  Carrier between the port logic and the external-clock shifter.
  The word is held stable by the system side while a read is open.
*/
`timescale 1ns/1ns
interface serial_link_if;
  logic [15:0] word;
  logic chain;
  logic sdo;
  modport port_side (output word, output chain, input sdo);
  modport shifter (input word, input chain, output sdo);
endinterface

// ### src/slave_shifter.sv
/*
  Shift register clocked by the host-supplied serial clock.
  Assumes the clock sense and reset are prepared by the port logic.
*/
`timescale 1ns/1ns
module slave_shifter (
  input wire logic link_clk_i,
  input wire logic link_rst_n_i,
  serial_link_if.shifter link
);
  logic loaded;
  logic sdo;
  logic [15:0] shreg;
  logic [4:0] edges;
  logic [15:0] src;

  assign src = loaded ? shreg : link.word;
  assign link.sdo = sdo;

  // Word is taken on the first edge of a read, chain bits follow behind it
  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      loaded <= 1'b0;
      sdo <= 1'b0;
      shreg <= adc_port_pkg::RESET_WORD;
    end else begin
      loaded <= 1'b1;
      sdo <= src[15];
      shreg <= {src[14:0], link.chain};
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      edges <= 5'h00;
    end else if (edges != adc_port_pkg::EDGE_SAT) begin
      edges <= edges + 5'h01;
    end
  end

  chain_delay_a: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i)
    (edges > adc_port_pkg::CHAIN_DELAY) |-> (sdo == $past(link.chain, 17))
  ) else $error("Chained bit not delayed by sixteen clocks");

  first_msb_a: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i)
    (edges == 5'h00) |=> (sdo == $past(link.word[15]))
  ) else $error("Serial word does not open with its top bit");
endmodule

// ### src/adc_result_port.sv
/*
  Result output port of a 16-bit converter: parallel word or serial stream,
  internal or host-supplied serial clock. Assumes the conversion core gives
  a result with a one-cycle valid pulse and a busy level on CLK_I, and that
  the host keeps the mode pins still during a read.
*/
// Overview of operation
// - Pins 0-3 always drive result bits 0-3
// - Parallel: shared serial pins carry bits 4-7
// - Parallel: serial data pin carries bit 8
// - Internal clock: device makes and drives SCLK
// - External clock: host supplies SCLK, data follows
// - Frame marker polarity set by its select pin
// - Clock invert flips SCLK sense, both modes
// - External clock: chain data follows after sixteen
// - Internal clock: chain pin picks read timing
// - Serial result leaves most significant bit first
// - Format pin chooses serial word coding
// - Internal clock: data stable on both edges
// - External, not inverted: change rising, sample falling
// - External, inverted: change falling, sample rising
// - Serial select low parallel, high serial
// - Format low inverts MSB for two's complement
// - Internal clock: frame marker active while serial data valid
// - Outputs enabled only with chip select, read
`timescale 1ns/1ns
module adc_result_port (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic [15:0] RESULT_I,
  input wire logic RESULT_VALID_I,
  input wire logic CONVERTING_I,
  input wire logic CS_N_I,
  input wire logic RD_N_I,
  input wire logic SERIAL_SELECT_I,
  input wire logic BINARY_FORMAT_SELECT_I,
  input wire logic CLOCK_SOURCE_SELECT_I,
  input wire logic FRAME_MARKER_POLARITY_I,
  input wire logic SERIAL_CLOCK_INVERT_I,
  input wire logic READ_MODE_OR_CHAIN_IN_I,
  input wire logic SCLK_I,
  output logic [15:0] DATA_O,
  output logic [15:0] DATA_OE_O
);
  logic [7:0] cfg_raw;
  logic [7:0] cfg_meta;
  logic [7:0] cfg;
  logic rd_act;
  logic ser_mode;
  logic fmt_bin;
  logic ext_clk;
  logic frame_pol;
  logic clk_inv;
  logic rdc;

  logic [15:0] result_raw;
  logic ready;
  logic [15:0] word_fmt;
  logic [15:0] held_word;

  adc_port_pkg::master_state_t state;
  adc_port_pkg::master_state_t next_state;
  logic start;
  logic [1:0] phase;
  logic [4:0] bitcnt;
  logic [15:0] shreg;
  logic sdo_m;
  logic sclk_m;
  logic frame_m;

  logic [15:0] data_q;
  logic [15:0] oe_q;
  logic [15:0] next_data;
  logic [15:0] next_oe;
  logic slave_sel;

  logic link_clk;
  logic link_rst_n;
  serial_link_if link ();

  // Pins are asynchronous to CLK_I; only the second stage is read
  assign cfg_raw = {READ_MODE_OR_CHAIN_IN_I, SERIAL_CLOCK_INVERT_I, FRAME_MARKER_POLARITY_I,
                    CLOCK_SOURCE_SELECT_I, BINARY_FORMAT_SELECT_I, SERIAL_SELECT_I,
                    RD_N_I, CS_N_I};

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cfg_meta <= adc_port_pkg::RESET_CFG;
      cfg <= adc_port_pkg::RESET_CFG;
    end else begin
      cfg_meta <= cfg_raw;
      cfg <= cfg_meta;
    end
  end

  assign rd_act = !cfg[adc_port_pkg::CFG_CS_N] && !cfg[adc_port_pkg::CFG_RD_N];
  assign ser_mode = cfg[adc_port_pkg::CFG_SERIAL];
  assign fmt_bin = cfg[adc_port_pkg::CFG_FORMAT];
  assign ext_clk = cfg[adc_port_pkg::CFG_EXT_CLK];
  assign frame_pol = cfg[adc_port_pkg::CFG_FRAME_POL];
  assign clk_inv = cfg[adc_port_pkg::CFG_CLK_INV];
  assign rdc = cfg[adc_port_pkg::CFG_READ_MODE];

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      result_raw <= adc_port_pkg::RESET_WORD;
    end else if (RESULT_VALID_I) begin
      result_raw <= RESULT_I;
    end
  end

  // A new result arriving as a frame starts keeps the flag set
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ready <= 1'b0;
    end else if (RESULT_VALID_I) begin
      ready <= 1'b1;
    end else if (start) begin
      ready <= 1'b0;
    end
  end

  assign word_fmt = fmt_bin ? result_raw : {~result_raw[15], result_raw[14:0]};

  // The shifter samples this copy on the host clock, so it only moves between reads
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      held_word <= adc_port_pkg::RESET_WORD;
    end else if (!rd_act) begin
      held_word <= word_fmt;
    end
  end

  // Read during the next conversion, or only once the core is idle
  assign start = ser_mode && !ext_clk && rd_act && ready &&
                 (rdc ? CONVERTING_I : !CONVERTING_I);

  always_comb begin
    next_state = state;
    unique case (state)
      adc_port_pkg::ST_IDLE: begin
        if (start) begin
          next_state = adc_port_pkg::ST_SHIFT;
        end
      end
      adc_port_pkg::ST_SHIFT: begin
        if (!rd_act) begin
          next_state = adc_port_pkg::ST_IDLE;
        end else if (phase == adc_port_pkg::PH_LAST && bitcnt == adc_port_pkg::LAST_BIT) begin
          next_state = adc_port_pkg::ST_HOLD;
        end
      end
      adc_port_pkg::ST_HOLD: begin
        if (!rd_act) begin
          next_state = adc_port_pkg::ST_IDLE;
        end
      end
      default: next_state = adc_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= adc_port_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Data moves only at the start of a bit; both SCLK edges fall inside it
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase <= adc_port_pkg::PH_UPDATE;
      bitcnt <= 5'h00;
      shreg <= adc_port_pkg::RESET_WORD;
      sdo_m <= 1'b0;
    end else if (state == adc_port_pkg::ST_IDLE && start) begin
      phase <= adc_port_pkg::PH_UPDATE;
      bitcnt <= 5'h00;
      shreg <= {word_fmt[14:0], 1'b0};
      sdo_m <= word_fmt[15];
    end else if (state == adc_port_pkg::ST_SHIFT) begin
      phase <= phase + 2'h1;
      if (phase == adc_port_pkg::PH_LAST && bitcnt != adc_port_pkg::LAST_BIT) begin
        bitcnt <= bitcnt + 5'h01;
        sdo_m <= shreg[15];
        shreg <= {shreg[14:0], 1'b0};
      end
    end
  end

  // SCLK is high for the two middle phases of each bit
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sclk_m <= 1'b0;
    end else begin
      sclk_m <= clk_inv ^ (state == adc_port_pkg::ST_SHIFT &&
                           (phase == adc_port_pkg::PH_UPDATE || phase == adc_port_pkg::PH_HIGH));
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      frame_m <= 1'b0;
    end else begin
      frame_m <= frame_pol ^ (next_state == adc_port_pkg::ST_SHIFT);
    end
  end

  always_comb begin
    next_data = word_fmt;
    if (ser_mode) begin
      next_data[7:4] = 4'h0;
      next_data[adc_port_pkg::PIN_SDO] = sdo_m;
      next_data[adc_port_pkg::PIN_SCLK] = sclk_m;
      next_data[adc_port_pkg::PIN_FRAME] = frame_m;
      next_data[adc_port_pkg::PIN_RDERR] = 1'b0;
    end
  end

  always_comb begin
    next_oe = 16'h0000;
    if (rd_act) begin
      next_oe = 16'hffff;
      next_oe[7:4] = {4{!ser_mode}};
      next_oe[adc_port_pkg::PIN_SCLK] = !(ser_mode && ext_clk);
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      data_q <= adc_port_pkg::RESET_WORD;
      oe_q <= 16'h0000;
      slave_sel <= 1'b0;
    end else begin
      data_q <= next_data;
      oe_q <= next_oe;
      slave_sel <= ser_mode && ext_clk;
    end
  end

  // Host clock sense is chosen by XOR with a pin held still during reads;
  // the read strobes end the frame, since the host clock may stop after it
  assign link_clk = SCLK_I ^ SERIAL_CLOCK_INVERT_I;
  assign link_rst_n = ARST_N_I && !CS_N_I && !RD_N_I;
  assign link.word = held_word;
  assign link.chain = READ_MODE_OR_CHAIN_IN_I;

  slave_shifter u_slave (
    .link_clk_i(link_clk),
    .link_rst_n_i(link_rst_n),
    .link(link.shifter)
  );

  always_comb begin
    DATA_O = data_q;
    DATA_O[adc_port_pkg::PIN_SDO] = slave_sel ? link.sdo : data_q[adc_port_pkg::PIN_SDO];
  end
  assign DATA_OE_O = oe_q;

  low_bits_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    rd_act |=> (DATA_OE_O[3:0] == 4'hf && DATA_O[3:0] == $past(word_fmt[3:0]))
  ) else $error("Low data pins not driven with result");

  parallel_mid_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (rd_act && !ser_mode) |=> (DATA_OE_O[7:4] == 4'hf && DATA_O[7:4] == $past(word_fmt[7:4]))
  ) else $error("Parallel bits 4 to 7 wrong");

  parallel_bit8_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (rd_act && !ser_mode) |=> (DATA_O[adc_port_pkg::PIN_SDO] == $past(word_fmt[8]))
  ) else $error("Parallel bit 8 wrong");

  bus_release_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    !rd_act |=> (DATA_OE_O == 16'h0000)
  ) else $error("Bus driven without read strobes");

  frame_level_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (state == adc_port_pkg::ST_SHIFT && $stable(frame_pol)) |-> (frame_m != frame_pol)
  ) else $error("Frame marker at wrong polarity");

  frame_length_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (state == adc_port_pkg::ST_IDLE && start && rd_act && $stable(cfg)) ##1 rd_act[*8]
    |-> ##56 (state == adc_port_pkg::ST_SHIFT) ##1 (state != adc_port_pkg::ST_SHIFT)
  ) else $error("Internal clock frame not sixty-four cycles");

  msb_first_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (state == adc_port_pkg::ST_IDLE && start) |=> (sdo_m == $past(word_fmt[15]))
  ) else $error("Serial frame does not open with top bit");

  stable_bit_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (state == adc_port_pkg::ST_SHIFT && phase != adc_port_pkg::PH_LAST) |=> $stable(sdo_m)
  ) else $error("Serial data moved inside a bit");

  read_timing_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (state == adc_port_pkg::ST_IDLE && next_state == adc_port_pkg::ST_SHIFT)
    |-> (rdc == CONVERTING_I)
  ) else $error("Frame started in wrong conversion phase");

  idle_clock_a: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (state != adc_port_pkg::ST_SHIFT) |=> (sclk_m == $past(clk_inv))
  ) else $error("Idle serial clock level ignores invert");
endmodule

// ### verification/host_model.sv
/*
  Host model for the result port: makes the external serial clock in bursts,
  feeds chain data and collects the serial output on the sampling edge.
  Assumes the bench opens the read strobes before calling run.
*/
`timescale 1ns/1ns
module host_model (
  input wire logic inv_i,
  input wire logic sdo_i,
  input wire logic [15:0] chain_i,
  output logic sclk_o,
  output logic chain_o,
  output logic [31:0] got_o
);
  logic busy = 1'b0;
  initial begin
    sclk_o = 1'b0;
    chain_o = 1'b0;
    got_o = 32'h0;
  end
  // Clock rests at its idle level between frames, never free-running
  always @(inv_i) if (!busy) sclk_o = inv_i;
  task automatic run();
    busy = 1'b1;
    got_o = 32'h0;
    sclk_o = inv_i;
    for (int i = 0; i < 32; i++) begin
      chain_o = (i < 16) ? chain_i[15 - i] : ~chain_o;
      #24 sclk_o = ~inv_i;
      #24 got_o = {got_o[30:0], sdo_i};
      sclk_o = inv_i;
    end
    // Released chain line must not keep showing the last bit
    chain_o = ~chain_o;
    busy = 1'b0;
  endtask
endmodule

// ### verification/adc_result_output_port_test.sv
/*
  Self-checking bench for the result port: parallel, host-clocked and
  internally clocked serial reads. Assumes the host model beside it.
*/
`timescale 1ns/1ns
module adc_result_output_port_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] result = 16'h0000;
  logic valid = 1'b0;
  logic conv = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic ser = 1'b0;
  logic fmt_sel = 1'b1;
  logic ext = 1'b0;
  logic pol = 1'b0;
  logic inv = 1'b0;
  logic rdc = 1'b0;
  logic [15:0] chain_pat = 16'h0000;
  logic sclk;
  logic chain;
  logic [31:0] host_got;
  logic [15:0] data;
  logic [15:0] oe;
  int num_errors = 0;
  int compares = 0;

  adc_result_port uut (
    .CLK_I(clk), .ARST_N_I(arst_n), .RESULT_I(result), .RESULT_VALID_I(valid),
    .CONVERTING_I(conv), .CS_N_I(cs_n), .RD_N_I(rd_n), .SERIAL_SELECT_I(ser),
    .BINARY_FORMAT_SELECT_I(fmt_sel), .CLOCK_SOURCE_SELECT_I(ext),
    .FRAME_MARKER_POLARITY_I(pol), .SERIAL_CLOCK_INVERT_I(inv),
    .READ_MODE_OR_CHAIN_IN_I(ext ? chain : rdc), .SCLK_I(sclk),
    .DATA_O(data), .DATA_OE_O(oe)
  );
  host_model host (
    .inv_i(inv), .sdo_i(data[8]), .chain_i(chain_pat),
    .sclk_o(sclk), .chain_o(chain), .got_o(host_got)
  );

  initial forever #5 clk = ~clk;

  function automatic logic [15:0] code(input logic f, input logic [15:0] w);
    return f ? w : {~w[15], w[14:0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Mode pins pass a two-flop synchroniser, so let them settle
  task automatic set_cfg(input logic s, f, e, p, i, r);
    @(posedge clk);
    ser <= s;
    fmt_sel <= f;
    ext <= e;
    pol <= p;
    inv <= i;
    rdc <= r;
    repeat (3) @(posedge clk);
  endtask

  task automatic load(input logic [15:0] w);
    @(posedge clk);
    result <= w;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
  endtask

  task automatic strobe(input logic v);
    @(posedge clk);
    cs_n <= v;
    rd_n <= v;
    repeat (4) @(posedge clk);
  endtask

  task automatic par_read(input logic f, input logic [15:0] w);
    set_cfg(1'b0, f, 1'b0, 1'b0, 1'b0, 1'b0);
    load(w);
    strobe(1'b0);
    check(oe, 16'hffff);
    check(data, code(f, w));
    strobe(1'b1);
    check(oe, 16'h0000);
  endtask

  task automatic ext_read(input logic i, f, input logic [15:0] w, c);
    set_cfg(1'b1, f, 1'b1, 1'b0, i, 1'b0);
    chain_pat = c;
    load(w);
    strobe(1'b0);
    check(oe, 16'hfd0f);
    host.run();
    check(host_got, {code(f, w), c});
    strobe(1'b1);
  endtask

  task automatic int_read(input logic p, i, f, r, input logic [15:0] w);
    logic [15:0] got;
    int bits;
    int act;
    logic ps;
    logic s;
    set_cfg(1'b1, f, 1'b0, p, i, r);
    @(posedge clk) conv <= ~r;
    load(w);
    strobe(1'b0);
    repeat (20) @(negedge clk);
    check(data[10], p);
    @(posedge clk) conv <= r;
    bits = 0;
    act = 0;
    got = 16'h0000;
    @(negedge clk);
    ps = data[9] ^ i;
    repeat (120) begin
      @(negedge clk);
      s = data[9] ^ i;
      if (data[10] != p) act++;
      if (s && !ps && data[10] != p) begin
        got = {got[14:0], data[8]};
        bits++;
      end else if (!s && ps && bits > 0) begin
        check(data[8], got[0]);
      end
      ps = s;
    end
    check(bits, 16);
    check(got, code(f, w));
    check(act, 64);
    check(oe, 16'hff0f);
    check(data & 16'hf8ff, code(f, w) & 16'hf00f);
    strobe(1'b1);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    par_read(1'b1, 16'ha5c3);
    par_read(1'b0, 16'h3c5a);
    ext_read(1'b0, 1'b1, 16'h8e71, 16'hc3a5);
    ext_read(1'b1, 1'b0, 16'h1f2e, 16'h5a0f);
    int_read(1'b0, 1'b0, 1'b1, 1'b0, 16'hb60d);
    int_read(1'b1, 1'b1, 1'b0, 1'b1, 16'h4c93);
    complete_run();
  end

  // Whole sequence needs well under 20 us; ten times that means a hang
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule
